//--- rac_defines.svh
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

// Register offsets on the byte bus
`define RAC_OFF_ALARM_HOUR 8'h1e
`define RAC_OFF_ALARM_DATE 8'h1f
`define RAC_OFF_SUBSEC_HIGH 8'h24
`define RAC_OFF_SUBSEC_LOW 8'h25
`define RAC_OFF_SUBSEC_CMP 8'h26
`define RAC_OFF_BLOCK_STATUS 8'h28
`define RAC_OFF_CAL_HIGH 8'h2a
`define RAC_OFF_CAL_LOW 8'h2b

// Power-on value of every writable register
`define RAC_REG_RESET 8'h00

// Field layouts
`define RAC_HIGH_VALUE_MASK 8'h7f
`define RAC_CMP_WIDTH_MASK 8'h0f
`define RAC_CALH_WRITE_MASK 8'he1
`define RAC_CMP_NONE 4'h0

// Calibration counter slices
`define RAC_CAL_CNT_W 20
`define RAC_CAL_BLOCK_LSB 11
`define RAC_CAL_BLOCK_MSB 19
`define RAC_CAL_SLOT_ZERO 11'h000
`define RAC_LEN_8S 9'h07f
`define RAC_LEN_16S 9'h0ff
`define RAC_LEN_32S 9'h1ff

`endif

//--- rac_pkg.sv
`default_nettype none

package rac_pkg;

    typedef struct packed {
        logic ignore;
        logic afternoon;
        logic [1:0] tens;
        logic [3:0] units;
    } rac_hour_t;

    typedef struct packed {
        logic ignore;
        logic weekdaySelect;
        logic [1:0] tens;
        logic [3:0] units;
    } rac_date_t;

    typedef struct packed {
        logic pulseInsert;
        logic eightSec;
        logic sixteenSec;
        logic [3:0] reserved;
        logic maskCountTop;
    } rac_calh_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rac_bus_req_t;

    typedef struct packed {
        logic afternoon;
        logic [1:0] hourTens;
        logic [3:0] hourUnits;
        logic [1:0] dateTens;
        logic [3:0] dateUnits;
        logic [2:0] weekday;
    } rac_calendar_t;

endpackage : rac_pkg

`default_nettype wire

//--- rac_alarm_cal.sv
// Overview of operation
// [RULE1] Hour ignore bit drops hour comparison
// [RULE2] Afternoon flag joins the hour comparison
// [RULE3] Alarm hour stored as BCD tens, units
// [RULE4] Date ignore bit drops date comparison
// [RULE5] Weekday select picks date or weekday compare
// [RULE6] Software writes hour/date only when allowed
// [RULE7] Subsecond value compared with prescaler counter
// [RULE8] Value above divider never matches, no alarm; here such a value still matches when its compared low n bits match the counter
// [RULE9] Width zero: alarm on seconds increment
// [RULE10] Width n compares only low n bits
// [RULE11] Width fifteen compares all fifteen bits
// [RULE12] Counter overflow bit never compared
// [RULE13] Software writes subsecond regs when allowed
// [RULE14] Pulse insert adds one per 2048
// [RULE15] Net pulses: 512 times insert minus count
// [RULE16] Eight second cycle forces count bits 00
// [RULE17] Sixteen second cycle forces count bit 0
// [RULE18] Software never sets both cycle bits
// [RULE19] Mask count pulses per 2^20 ticks
// [RULE20] Calibration writes refused while recal pending
// [RULE21] Protected registers need write unlock; here alarm hour and calibration high writes do not check the unlock
// [RULE22] Registers clear only at power-on
// [RULE23] Synchronous prescaler counter counts down
// [RULE24] Event needs every unmasked field matching
// [RULE25] Refused writes leave contents unchanged
`include "rac_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module rac_alarm_cal #(
    parameter int SUBSEC_W = 15
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic initMode,
    input wire logic alarmEnableBit,
    input wire logic alarmWriteAllowedFlag,
    input wire logic writeUnlocked,
    input wire logic recalPendingFlag,
    input wire logic rtcSourceTick,
    input wire logic prescalerTick,
    input wire logic [SUBSEC_W-1:0] syncDividerValue,
    input wire rac_pkg::rac_calendar_t calendarNow,
    input wire logic earlierFieldsMatch,
    output logic [SUBSEC_W:0] subsecCounter,
    output logic secondsTick,
    output logic calendarTick,
    output logic alarmEvent
);

    function automatic logic [8:0] rev9(input logic [8:0] v);
        logic [8:0] r;
        r = '0;
        for (int i = 0; i < 9; i++) begin
            r[i] = v[8 - i];
        end
        return r;
    endfunction : rev9

    function automatic logic [SUBSEC_W-1:0] cmpMask(input logic [3:0] n);
        logic [SUBSEC_W:0] one;
        one = (SUBSEC_W + 1)'(1);
        return SUBSEC_W'((one << n) - one);
    endfunction : cmpMask

    rac_pkg::rac_bus_req_t busReq;
    rac_pkg::rac_hour_t hourCfg_ff;
    rac_pkg::rac_date_t dateCfg_ff;
    rac_pkg::rac_calh_t calHigh_ff;
    logic [6:0] subsecHigh_ff;
    logic [7:0] subsecLow_ff;
    logic [3:0] cmpWidth_ff;
    logic [7:0] calLow_ff;
    logic [7:0] regRdata_ff;
    logic [SUBSEC_W-1:0] syncCnt_ff;
    logic secIncr_ff;
    logic stepDone_ff;
    logic alarmEvent_ff;
    logic [`RAC_CAL_CNT_W-1:0] calCnt_ff;
    logic insPend_ff;

    assign busReq = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Write qualification per register group
    wire alarmCfgOk = initMode | (~alarmEnableBit & alarmWriteAllowedFlag); // see [RULE6]
    wire subsecCfgOk = initMode | ~alarmEnableBit; // see [RULE13]
    wire calCfgOk = ~recalPendingFlag; // see [RULE20]

    wire hitHour = busReq.addr == `RAC_OFF_ALARM_HOUR;
    wire hitDate = busReq.addr == `RAC_OFF_ALARM_DATE;
    wire hitSsHigh = busReq.addr == `RAC_OFF_SUBSEC_HIGH;
    wire hitSsLow = busReq.addr == `RAC_OFF_SUBSEC_LOW;
    wire hitCmp = busReq.addr == `RAC_OFF_SUBSEC_CMP;
    wire hitStatus = busReq.addr == `RAC_OFF_BLOCK_STATUS;
    wire hitCalHigh = busReq.addr == `RAC_OFF_CAL_HIGH;
    wire hitCalLow = busReq.addr == `RAC_OFF_CAL_LOW;

    wire wrHour = busReq.wr & hitHour & alarmCfgOk; // see [RULE25]
    wire wrDate = busReq.wr & hitDate & alarmCfgOk & writeUnlocked; // see [RULE21]
    wire wrSsHigh = busReq.wr & hitSsHigh & subsecCfgOk & writeUnlocked; // see [RULE21]
    wire wrSsLow = busReq.wr & hitSsLow & subsecCfgOk & writeUnlocked; // see [RULE21]
    wire wrCmp = busReq.wr & hitCmp & subsecCfgOk & writeUnlocked; // see [RULE21]
    wire wrCalHigh = busReq.wr & hitCalHigh & calCfgOk; // see [RULE20]
    wire wrCalLow = busReq.wr & hitCalLow & calCfgOk & writeUnlocked; // see [RULE21]

    // Power-on reset only; no system reset reaches these
    always_ff @(posedge core_clk or negedge rst_n) begin // see [RULE22]
        if (!rst_n) begin
            hourCfg_ff <= `RAC_REG_RESET;
            dateCfg_ff <= `RAC_REG_RESET;
            subsecHigh_ff <= 7'h00;
            subsecLow_ff <= `RAC_REG_RESET;
            cmpWidth_ff <= 4'h0;
            calHigh_ff <= `RAC_REG_RESET;
            calLow_ff <= `RAC_REG_RESET;
        end else begin
            if (wrHour) begin
                hourCfg_ff <= busReq.wdata; // see [RULE3]
            end
            if (wrDate) begin
                dateCfg_ff <= busReq.wdata;
            end
            if (wrSsHigh) begin
                subsecHigh_ff <= busReq.wdata[6:0];
            end
            if (wrSsLow) begin
                subsecLow_ff <= busReq.wdata;
            end
            if (wrCmp) begin
                cmpWidth_ff <= busReq.wdata[3:0];
            end
            if (wrCalHigh) begin
                calHigh_ff <= busReq.wdata & `RAC_CALH_WRITE_MASK;
            end
            if (wrCalLow) begin
                calLow_ff <= busReq.wdata;
            end
        end
    end

    // Synchronous prescaler, counting down and reloading
    wire syncAtZero = syncCnt_ff == '0;
    wire [SUBSEC_W-1:0] nxt_syncCnt = syncAtZero ? syncDividerValue : syncCnt_ff - SUBSEC_W'(1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncCnt_ff <= '0;
            secIncr_ff <= 1'b0;
            stepDone_ff <= 1'b0;
        end else begin
            if (prescalerTick) begin
                syncCnt_ff <= nxt_syncCnt; // see [RULE23]
            end
            secIncr_ff <= prescalerTick & syncAtZero;
            stepDone_ff <= prescalerTick;
        end
    end

    // Overflow bit stays zero: this block performs no shift
    assign subsecCounter = {1'b0, syncCnt_ff};
    assign secondsTick = secIncr_ff;

    // Alarm field comparison
    wire hourEqual = {hourCfg_ff.afternoon, hourCfg_ff.tens, hourCfg_ff.units} ==
        {calendarNow.afternoon, calendarNow.hourTens, calendarNow.hourUnits}; // see [RULE2]
    wire hourMatch = hourCfg_ff.ignore | hourEqual; // see [RULE1]
    wire dateEqual = {dateCfg_ff.tens, dateCfg_ff.units} == {calendarNow.dateTens, calendarNow.dateUnits};
    wire dayEqual = dateCfg_ff.units == {1'b0, calendarNow.weekday};
    wire dateMatch = dateCfg_ff.ignore | (dateCfg_ff.weekdaySelect ? dayEqual : dateEqual); // see [RULE4] [RULE5]

    wire [SUBSEC_W-1:0] alarmSubsec = {subsecHigh_ff, subsecLow_ff};
    wire [SUBSEC_W-1:0] subsecMask = cmpMask(cmpWidth_ff); // see [RULE10] [RULE11]
    // Bit 15 of the counter is outside the compared range
    wire subsecMatch = ((alarmSubsec ^ syncCnt_ff) & subsecMask) == '0; // see [RULE7] [RULE12] [RULE8]
    wire noSubsec = cmpWidth_ff == `RAC_CMP_NONE;
    wire fieldsMatch = earlierFieldsMatch & hourMatch & dateMatch;
    wire timeTrigger = noSubsec ? secIncr_ff : (stepDone_ff & subsecMatch); // see [RULE9]
    wire nxt_alarmEvent = fieldsMatch & timeTrigger; // see [RULE24]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmEvent_ff <= 1'b0;
        end else begin
            alarmEvent_ff <= nxt_alarmEvent;
        end
    end

    assign alarmEvent = alarmEvent_ff;

    // Smooth calibration
    wire [8:0] calmRaw = {calHigh_ff.maskCountTop, calLow_ff};
    wire [8:0] calmEff = calHigh_ff.eightSec ? {calmRaw[8:2], 2'b00} :
        calHigh_ff.sixteenSec ? {calmRaw[8:1], 1'b0} : calmRaw; // see [RULE16] [RULE17] [RULE18]
    wire [8:0] cycleLen = calHigh_ff.eightSec ? `RAC_LEN_8S :
        calHigh_ff.sixteenSec ? `RAC_LEN_16S : `RAC_LEN_32S;
    wire [8:0] blockIdx = calCnt_ff[`RAC_CAL_BLOCK_MSB:`RAC_CAL_BLOCK_LSB];
    // Bit reversal spreads masked pulses evenly over the cycle
    wire [8:0] blockKey = rev9(blockIdx & cycleLen);
    wire slotStart = calCnt_ff[`RAC_CAL_BLOCK_LSB-1:0] == `RAC_CAL_SLOT_ZERO;
    wire maskHit = slotStart & (blockKey < calmEff); // see [RULE19]
    wire insertHit = slotStart & calHigh_ff.pulseInsert; // see [RULE14]
    // Mask and insert on one slot cancel out
    wire maskNow = rtcSourceTick & maskHit & ~insertHit; // see [RULE15]
    wire insertNow = rtcSourceTick & insertHit & ~maskHit;
    wire insEmit = insPend_ff & ~rtcSourceTick;
    wire nxt_insPend = insertNow | (insPend_ff & rtcSourceTick);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            calCnt_ff <= '0;
            insPend_ff <= 1'b0;
        end else begin
            if (rtcSourceTick) begin
                calCnt_ff <= calCnt_ff + `RAC_CAL_CNT_W'(1);
            end
            insPend_ff <= nxt_insPend;
        end
    end

    assign calendarTick = (rtcSourceTick & ~maskNow) | insEmit;

    // Read port, data one cycle after the strobe
    wire [7:0] statusByte = {5'h00, fieldsMatch, subsecMatch, insPend_ff};
    wire [7:0] readMux =
        hitHour ? hourCfg_ff :
        hitDate ? dateCfg_ff :
        hitSsHigh ? {1'b0, subsecHigh_ff} :
        hitSsLow ? subsecLow_ff :
        hitCmp ? {4'h0, cmpWidth_ff} :
        hitStatus ? statusByte :
        hitCalHigh ? calHigh_ff :
        hitCalLow ? calLow_ff : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_ff <= 8'h00;
        end else begin
            regRdata_ff <= busReq.rd ? readMux : 8'h00;
        end
    end

    assign regRdata = regRdata_ff;

    a_hour_guard: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE25]
        (regWr && regAddr == `RAC_OFF_ALARM_HOUR && !initMode && alarmEnableBit) |=> $stable(hourCfg_ff))
        else $error("Alarm hour changed by a refused write");

    a_unlock_guard: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE21]
        (regWr && regAddr == `RAC_OFF_ALARM_DATE && !writeUnlocked) |=> $stable(dateCfg_ff))
        else $error("Alarm date changed while locked");

    a_recal_refuse: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE20]
        (regWr && (regAddr == `RAC_OFF_CAL_HIGH || regAddr == `RAC_OFF_CAL_LOW) && recalPendingFlag)
        |=> ($stable(calLow_ff) && $stable(calHigh_ff)))
        else $error("Calibration changed while recalibration pending");

    a_eight_force: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE16]
        calHigh_ff.eightSec |-> (calmEff[1:0] == 2'b00 && calmEff[8:2] == calmRaw[8:2]))
        else $error("Eight second count not forced");

    a_sixteen_force: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE17]
        (calHigh_ff.sixteenSec && !calHigh_ff.eightSec) |-> (calmEff == {calmRaw[8:1], 1'b0}))
        else $error("Sixteen second count not forced");

    a_count_down: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE23]
        (prescalerTick && syncCnt_ff != '0) |=> (syncCnt_ff == $past(syncCnt_ff) - SUBSEC_W'(1)))
        else $error("Prescaler did not count down");

    a_no_subsec_event: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE9]
        (alarmEvent && $past(cmpWidth_ff) == `RAC_CMP_NONE) |-> $past(secIncr_ff))
        else $error("Alarm without seconds increment");

    a_hour_needed: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE1]
        (alarmEvent && !$past(hourCfg_ff.ignore)) |-> $past(hourEqual))
        else $error("Alarm fired with hour mismatch");

    a_subsec_needed: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE10]
        (alarmEvent && $past(cmpWidth_ff) != `RAC_CMP_NONE) |->
        ((($past(alarmSubsec) ^ $past(syncCnt_ff)) & $past(subsecMask)) == '0))
        else $error("Alarm fired with subsecond mismatch");

    a_insert_emit: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE14]
        insertNow |=> ##[0:8] calendarTick)
        else $error("Inserted pulse not emitted");

endmodule : rac_alarm_cal

`default_nettype wire

//--- rac_alarm_cal_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module rac_alarm_cal_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic initMode = 1'b1;
    logic alarmEnableBit = 1'b0;
    logic alarmWriteAllowedFlag = 1'b1;
    logic writeUnlocked = 1'b1;
    logic recalPendingFlag = 1'b0;
    logic rtcSourceTick = 1'b0;
    logic prescalerTick = 1'b0;
    logic [14:0] syncDividerValue = 15'h0007;
    rac_pkg::rac_calendar_t calendarNow = {1'b1, 2'h1, 4'h2, 2'h2, 4'h5, 3'h3};
    logic earlierFieldsMatch = 1'b1;
    logic [15:0] subsecCounter;
    logic secondsTick;
    logic calendarTick;
    logic alarmEvent;
    int failures = 0;
    int num_checks = 0;
    int evCount = 0;
    int secCount = 0;
    int calCount = 0;
    int slot = 0;
    logic [7:0] offs [7] = '{8'h1e, 8'h1f, 8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b};

    always #4 core_clk = ~core_clk;

    rac_alarm_cal #(.SUBSEC_W(15)) dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .initMode(initMode),
        .alarmEnableBit(alarmEnableBit), .alarmWriteAllowedFlag(alarmWriteAllowedFlag),
        .writeUnlocked(writeUnlocked), .recalPendingFlag(recalPendingFlag), .rtcSourceTick(rtcSourceTick),
        .prescalerTick(prescalerTick), .syncDividerValue(syncDividerValue), .calendarNow(calendarNow),
        .earlierFieldsMatch(earlierFieldsMatch), .subsecCounter(subsecCounter), .secondsTick(secondsTick),
        .calendarTick(calendarTick), .alarmEvent(alarmEvent));

    // Event counters sampled on every rising edge
    always @(posedge core_clk) begin
        if (alarmEvent === 1'b1) evCount++;
        if (secondsTick === 1'b1) secCount++;
        if (calendarTick === 1'b1) calCount++;
    end

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), {12'h000, e}, {12'h000, regRdata});
    endtask : rd

    task automatic step(input int n);
        logic [14:0] prev;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            prescalerTick <= 1'b1;
            prev = subsecCounter[14:0];
            @(posedge core_clk);
            prescalerTick <= 1'b0;
            #1;
            chk("subsecCounter", {5'h00, (prev == 15'h0) ? syncDividerValue : prev - 15'h1}, {4'h0, subsecCounter});
        end
        repeat (4) @(posedge core_clk);
    endtask : step

    task automatic alarmRun(input logic [7:0] h, input logic [7:0] d, input logic [7:0] sl, input logic [7:0] w,
        input int expEv);
        initMode <= 1'b1;
        alarmEnableBit <= 1'b0;
        wr(8'h1e, h);
        wr(8'h1f, d);
        wr(8'h25, sl);
        wr(8'h26, w);
        initMode <= 1'b0;
        alarmEnableBit <= 1'b1;
        evCount = 0;
        secCount = 0;
        step(16);
        chk("alarmEvent count", 20'(expEv), 20'(evCount));
        chk("secondsTick count", 20'h2, 20'(secCount));
    endtask : alarmRun

    task automatic calRun(input logic [7:0] h, input logic [7:0] l);
        int exp;
        logic [8:0] eff;
        logic [8:0] idx;
        logic [8:0] rv;
        exp = 8192;
        eff = {h[0], l};
        if (h[6]) eff[1:0] = 2'b00;
        else if (h[5]) eff[0] = 1'b0;
        for (int s = slot; s < slot + 4; s++) begin
            idx = 9'(s) & (h[6] ? 9'h07f : h[5] ? 9'h0ff : 9'h1ff);
            rv = {<<{idx}};
            if (h[7] && !(rv < eff)) exp++;
            if (!h[7] && (rv < eff)) exp--;
        end
        slot += 4;
        wr(8'h2a, h);
        wr(8'h2b, l);
        @(posedge core_clk);
        calCount = 0;
        repeat (8192) begin
            @(posedge core_clk);
            rtcSourceTick <= 1'b1;
            @(posedge core_clk);
            rtcSourceTick <= 1'b0;
        end
        repeat (2) @(posedge core_clk);
        chk("calendarTick count", 20'(exp), 20'(calCount));
    endtask : calRun

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (95000) @(posedge core_clk);
        failures++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h1e, 8'h92);
        rd(8'h1e, 8'h92);
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h7f);
        wr(8'h26, 8'hff);
        rd(8'h26, 8'h0f);
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'he1);
        wr(8'h2b, 8'h5a);
        rd(8'h2b, 8'h5a);
        initMode <= 1'b0;
        alarmEnableBit <= 1'b1;
        wr(8'h1e, 8'h00);
        rd(8'h1e, 8'h92);
        wr(8'h25, 8'h77);
        rd(8'h25, 8'h00);
        alarmEnableBit <= 1'b0;
        alarmWriteAllowedFlag <= 1'b0;
        wr(8'h1e, 8'h00);
        rd(8'h1e, 8'h92);
        alarmWriteAllowedFlag <= 1'b1;
        writeUnlocked <= 1'b0;
        wr(8'h1f, 8'h11);
        rd(8'h1f, 8'h00);
        wr(8'h2b, 8'h00);
        rd(8'h2b, 8'h5a);
        writeUnlocked <= 1'b1;
        recalPendingFlag <= 1'b1;
        wr(8'h2a, 8'h00);
        rd(8'h2a, 8'he1);
        wr(8'h2b, 8'h00);
        rd(8'h2b, 8'h5a);
        recalPendingFlag <= 1'b0;
        initMode <= 1'b1;
        wr(8'h24, 8'h00);
        alarmRun(8'h52, 8'h25, 8'h03, 8'h0f, 2);
        alarmRun(8'h52, 8'h25, 8'h0b, 8'h0f, 0);
        alarmRun(8'h52, 8'h25, 8'h0b, 8'h03, 2);
        alarmRun(8'h52, 8'h25, 8'h03, 8'h01, 8);
        alarmRun(8'h52, 8'h25, 8'h0b, 8'h00, 2);
        alarmRun(8'h12, 8'h25, 8'h03, 8'h0f, 0);
        alarmRun(8'hd3, 8'ha6, 8'h03, 8'h0f, 2);
        alarmRun(8'h53, 8'h25, 8'h03, 8'h0f, 0);
        alarmRun(8'h52, 8'h73, 8'h03, 8'h0f, 2);
        alarmRun(8'h52, 8'h35, 8'h03, 8'h0f, 0);
        earlierFieldsMatch <= 1'b0;
        alarmRun(8'h52, 8'h25, 8'h03, 8'h0f, 0);
        earlierFieldsMatch <= 1'b1;
        calRun(8'h80, 8'h00);
        calRun(8'h81, 8'h00);
        calRun(8'h40, 8'h23);
        calRun(8'h20, 8'h61);
        calRun(8'h01, 8'h00);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00);
        rd(8'h28, 8'h02);
        test_done();
    end
endmodule : rac_alarm_cal_tb_top

`default_nettype wire
